// ===== design/srrt_params.svh
/*
 * Constants for the short-circuit ride-through block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes it is included by the package, the top module and the bench.
 */
`ifndef SRRT_PARAMS_SVH
`define SRRT_PARAMS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define SRRT_CLK_PERIOD_NS  100
`define SRRT_TICK_NS        250
`define SRRT_TICK_CYC       \
    ((`SRRT_TICK_NS + `SRRT_CLK_PERIOD_NS - 1) / `SRRT_CLK_PERIOD_NS)
`define SRRT_RIDE_MAX_NS    63750
`define SRRT_TIMER_W        8
`define SRRT_EDGE_TICKS     8'h01
`define SRRT_TICK_CNT_W     2

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define SRRT_ADDR_W         8
`define SRRT_ADDR_CTRL      8'h00
`define SRRT_ADDR_CMD       8'h04
`define SRRT_ADDR_STATUS    8'h08
`define SRRT_ADDR_INT_STAT  8'h0C
`define SRRT_ADDR_INT_MASK  8'h10
`define SRRT_ADDR_LIMIT     8'h14

// ****************************************************************
// Fields, reset values, answers
// ****************************************************************
`define SRRT_CMD_TURNOFF_REL 0
`define SRRT_CMD_FAULT_REL   1
`define SRRT_CMD_ACC_CLR     2
`define SRRT_EV_W            4
`define SRRT_EV_FAULT        0
`define SRRT_EV_TRIP         1
`define SRRT_EV_OVF          2
`define SRRT_EV_OVERCUR      3
`define SRRT_CTRL_RST        32'h00FF_FF00
`define SRRT_INT_MASK_RST    4'h0
`define SRRT_ADC_W           10
`define SRRT_LIMIT_COUNTS    10'h1A6
`define SRRT_RESP_OKAY       2'h0
`define SRRT_RESP_SLVERR     2'h2

`endif

// ===== design/srrt_pkg.sv
/*
 * Types shared by the short-circuit ride-through block.
 * Assumes srrt_params.svh is on the include path.
 */
`include "srrt_params.svh"

package srrt_pkg;

    // Control word as software sees it
    typedef struct packed {
        logic [7:0]               rsvd_hi;
        logic [`SRRT_TIMER_W-1:0] acc_period;
        logic [`SRRT_TIMER_W-1:0] holdoff_ticks;
        logic [4:0]               rsvd_lo;
        logic                     auto_release;
        logic                     ride_mode;
        logic                     drive_on;
    } srrt_ctrl_s;

    // Read-only status word
    typedef struct packed {
        logic [7:0]               rsvd_hi;
        logic [`SRRT_TIMER_W-1:0] holdoff_count;
        logic [`SRRT_TIMER_W-1:0] acc_count;
        logic [2:0]               rsvd_lo;
        logic                     gate_discharge;
        logic                     gate_drive_high;
        logic                     overflow_readback;
        logic                     turnoff_latch_out;
        logic                     fault_latch_out;
    } srrt_status_s;

    // State of the top module, apart from the two timer counts
    typedef struct packed {
        srrt_ctrl_s                 ctrl;
        logic                       fault_set;
        logic                       turnoff;
        logic                       ovf_flag;
        logic                       ovf_rb;
        logic                       gdh;
        logic                       gde;
        logic                       irq;
        logic [`SRRT_EV_W-1:0]      int_stat;
        logic [`SRRT_EV_W-1:0]      int_mask;
        logic [`SRRT_TICK_CNT_W-1:0] tick_cnt;
        logic                       osc_tick;
        logic                       awready;
        logic                       wready;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       arready;
        logic                       rvalid;
        logic [1:0]                 rresp;
        logic [31:0]                rdata;
    } srrt_state_s;

endpackage : srrt_pkg

// ===== design/srrt_timer.sv
/*
 * Gated tick counter used for the hold-off and accumulating timers.
 * Assumes tick is a one-cycle enable and run is a synchronous level.
 */
`timescale 1ns/1ps

module srrt_timer #(
    parameter int W = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         run,
    input  wire logic         tick,
    input  wire logic         clear,
    input  wire logic [W-1:0] period,
    output logic      [W-1:0] count,
    output logic              hit
);

    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    logic [W:0]   count_inc;

    // Count saturates at the period so it never wraps past a trip
    assign count_inc = {1'b0, count_r} + {{W{1'b0}}, 1'b1};
    assign hit       = run && tick && (count_inc >= {1'b0, period});
    assign count     = count_r;

    // Clear beats the advance; hit still reports the event
    always_comb begin
        count_nxt = count_r;
        if (clear) begin
            count_nxt = '0;
        end else if (run && tick && (count_r < period)) begin
            count_nxt = count_inc[W-1:0];
        end
    end

    // Registered count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule : srrt_timer

// ===== design/srrt_top.sv
/*
 * Short-circuit ride-through logic: fault latch, hold-off timer,
 * turn-off latch, gated accumulating timer, AXI4-Lite register slave.
 * Assumes all inputs are synchronous to aclk and the gate driver
 * follows gate_drive_high_enable and gate_discharge_enable directly.
 */
`timescale 1ns/1ps
`include "srrt_params.svh"

// Notes on behaviour
// - fault latch drives gate enable, timer, gate
// - hold-off timer counts only while faulted
// - hold-off overflow sets the turn-off latch
// - turn-off latch drives discharge enable pin
// - edge mode overflows after one 300 ns tick
// - fast tick gated by fault clocks accumulator in ride mode
// - accumulator keeps count across transient faults
// - accumulator overflow forces gate enable low
// - overflow flag buffered into readable signal
// - firmware clears accumulator count on overflow
// - over-current limit fixed at 422 counts
// - comparator high sets fault, drops enable
// - ride-through at most 76.5 us, 300 ns steps
// - discharge enable never high with drive enable
module srrt_top #(
    parameter int ADDR_W = `SRRT_ADDR_W
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [ADDR_W-1:0]       awaddr,
    input  wire logic [2:0]              awprot,
    input  wire logic                    awvalid,
    output logic                         awready,
    input  wire logic [31:0]             wdata,
    input  wire logic [3:0]              wstrb,
    input  wire logic                    wvalid,
    output logic                         wready,
    output logic [1:0]                   bresp,
    output logic                         bvalid,
    input  wire logic                    bready,
    input  wire logic [ADDR_W-1:0]       araddr,
    input  wire logic [2:0]              arprot,
    input  wire logic                    arvalid,
    output logic                         arready,
    output logic [31:0]                  rdata,
    output logic [1:0]                   rresp,
    output logic                         rvalid,
    input  wire logic                    rready,
    input  wire logic                    short_circuit_compare_out,
    input  wire logic [`SRRT_ADC_W-1:0]  adc_result,
    input  wire logic                    adc_valid,
    output logic                         gate_drive_high_enable,
    output logic                         gate_discharge_enable,
    output logic                         overflow_readback,
    output logic                         irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    srrt_pkg::srrt_state_s          s_r;
    srrt_pkg::srrt_state_s          s_nxt;
    srrt_pkg::srrt_status_s         status_w;
    logic [ADDR_W-1:0]              waddr;
    logic [ADDR_W-1:0]              raddr;
    logic                           wr_go;
    logic                           rd_go;
    logic                           cmd_hit;
    logic                           turnoff_rel;
    logic                           fault_rel;
    logic                           acc_clr;
    logic                           acc_run;
    logic [`SRRT_TIMER_W-1:0]       hold_period;
    logic [`SRRT_TIMER_W-1:0]       hold_cnt;
    logic                           hold_hit;
    logic [`SRRT_TIMER_W-1:0]       acc_cnt;
    logic                           acc_hit;
    logic                           overcur;
    logic [`SRRT_EV_W-1:0]          events;
    logic                           fault_latch_out;

    // Byte-lane merge for writable words
    function automatic logic [31:0] srrt_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] m;
        m = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return m;
    endfunction : srrt_merge

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // Word-aligned addresses; low two bits are ignored
    assign waddr       = {awaddr[ADDR_W-1:2], 2'h0};
    assign raddr       = {araddr[ADDR_W-1:2], 2'h0};
    assign wr_go       = s_r.awready && awvalid && wvalid;
    assign rd_go       = s_r.arready && arvalid;
    assign cmd_hit     = wr_go && (waddr == `SRRT_ADDR_CMD) && wstrb[0];
    assign turnoff_rel = cmd_hit && wdata[`SRRT_CMD_TURNOFF_REL];
    assign fault_rel   = cmd_hit && wdata[`SRRT_CMD_FAULT_REL];
    assign acc_clr     = cmd_hit && wdata[`SRRT_CMD_ACC_CLR];

    // ****************************************************************
    // Timers
    // ****************************************************************
    // Low fault latch output gates both timers and the fast tick
    assign fault_latch_out = ~s_r.fault_set;
    // Edge mode loads a one-tick period; 8 bits cap ride at 76.5 us
    assign hold_period = s_r.ctrl.ride_mode ?
                         s_r.ctrl.holdoff_ticks : `SRRT_EDGE_TICKS;
    // Accumulator only runs in ride-through mode
    assign acc_run = s_r.fault_set && s_r.ctrl.ride_mode;

    srrt_timer #(
        .W      (`SRRT_TIMER_W)
    ) u_holdoff (
        .aclk   (aclk),
        .aresetn(aresetn),
        .run    (s_r.fault_set),
        .tick   (s_r.osc_tick),
        .clear  (turnoff_rel),
        .period (hold_period),
        .count  (hold_cnt),
        .hit    (hold_hit)
    );

    srrt_timer #(
        .W      (`SRRT_TIMER_W)
    ) u_accum (
        .aclk   (aclk),
        .aresetn(aresetn),
        .run    (acc_run),
        .tick   (s_r.osc_tick),
        .clear  (acc_clr),
        .period (s_r.ctrl.acc_period),
        .count  (acc_cnt),
        .hit    (acc_hit)
    );

    // Over-current check against the fixed shunt limit
    assign overcur = adc_valid && (adc_result > `SRRT_LIMIT_COUNTS);

    // Status word as read by software
    always_comb begin
        status_w                   = '0;
        status_w.holdoff_count     = hold_cnt;
        status_w.acc_count         = acc_cnt;
        status_w.gate_discharge    = s_r.gde;
        status_w.gate_drive_high   = s_r.gdh;
        status_w.overflow_readback = s_r.ovf_rb;
        status_w.turnoff_latch_out = s_r.turnoff;
        status_w.fault_latch_out   = fault_latch_out;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_nxt = s_r;

        // Fast tick divider: 250 ns rounds up to whole cycles
        if (s_r.tick_cnt == `SRRT_TICK_CNT_W'(`SRRT_TICK_CYC - 1)) begin
            s_nxt.tick_cnt = '0;
            s_nxt.osc_tick = 1'b1;
        end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + `SRRT_TICK_CNT_W'(1);
            s_nxt.osc_tick = 1'b0;
        end

        // Overflow flag: set wins over firmware clear
        s_nxt.ovf_flag = acc_hit || (s_r.ovf_flag && !acc_clr);
        // Registered copy, one cycle behind, so software can see the flag
        s_nxt.ovf_rb   = s_r.ovf_flag;

        // Fault latch set by comparator or overflow; release is
        // refused while either source is still active
        s_nxt.fault_set = short_circuit_compare_out || s_nxt.ovf_flag ||
                          (s_r.fault_set &&
                           !(s_r.ctrl.auto_release || fault_rel));

        // Turn-off latch: hold-off overflow sets, only firmware clears
        s_nxt.turnoff = hold_hit || (s_r.turnoff && !turnoff_rel);

        // Register writes
        s_nxt.awready = awvalid && wvalid && !s_r.awready && !s_r.bvalid;
        s_nxt.wready  = awvalid && wvalid && !s_r.awready && !s_r.bvalid;
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (wr_go) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = `SRRT_RESP_OKAY;
            unique case (waddr)
                `SRRT_ADDR_CTRL: begin
                    s_nxt.ctrl = srrt_merge(s_r.ctrl, wdata, wstrb);
                    s_nxt.ctrl.rsvd_hi = '0;
                    s_nxt.ctrl.rsvd_lo = '0;
                end
                `SRRT_ADDR_INT_MASK: begin
                    if (wstrb[0]) begin
                        s_nxt.int_mask = wdata[`SRRT_EV_W-1:0];
                    end
                end
                `SRRT_ADDR_CMD, `SRRT_ADDR_INT_STAT,
                `SRRT_ADDR_STATUS, `SRRT_ADDR_LIMIT: begin
                end
                default: begin
                    s_nxt.bresp = `SRRT_RESP_SLVERR;
                end
            endcase
        end

        // Sticky events; a new event beats a write-one clear
        events[`SRRT_EV_FAULT]   = s_nxt.fault_set && !s_r.fault_set;
        events[`SRRT_EV_TRIP]    = s_nxt.turnoff && !s_r.turnoff;
        events[`SRRT_EV_OVF]     = s_nxt.ovf_flag && !s_r.ovf_flag;
        events[`SRRT_EV_OVERCUR] = overcur;
        s_nxt.int_stat = s_r.int_stat;
        if (wr_go && (waddr == `SRRT_ADDR_INT_STAT) && wstrb[0]) begin
            s_nxt.int_stat = s_r.int_stat & ~wdata[`SRRT_EV_W-1:0];
        end
        s_nxt.int_stat = s_nxt.int_stat | events;
        s_nxt.irq      = |(s_nxt.int_stat & s_nxt.int_mask);

        // Gate outputs: never both high at once
        s_nxt.gdh = s_nxt.ctrl.drive_on && !s_nxt.fault_set &&
                    !s_nxt.turnoff;
        s_nxt.gde = s_nxt.turnoff && !s_nxt.gdh;

        // Register reads, answered one cycle after the address
        s_nxt.arready = arvalid && !s_r.arready && !s_r.rvalid;
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (rd_go) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = `SRRT_RESP_OKAY;
            s_nxt.rdata  = '0;
            unique case (raddr)
                `SRRT_ADDR_CTRL:     s_nxt.rdata = s_r.ctrl;
                `SRRT_ADDR_STATUS:   s_nxt.rdata = status_w;
                `SRRT_ADDR_INT_STAT: s_nxt.rdata[`SRRT_EV_W-1:0] = s_r.int_stat;
                `SRRT_ADDR_INT_MASK: s_nxt.rdata[`SRRT_EV_W-1:0] = s_r.int_mask;
                `SRRT_ADDR_LIMIT:    s_nxt.rdata[`SRRT_ADC_W-1:0] =
                                         `SRRT_LIMIT_COUNTS;
                `SRRT_ADDR_CMD: begin
                end
                default:             s_nxt.rresp = `SRRT_RESP_SLVERR;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Reset leaves drive off, discharge off, latches clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r          <= '0;
            s_r.ctrl     <= `SRRT_CTRL_RST;
            s_r.int_mask <= `SRRT_INT_MASK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flops
    assign awready                = s_r.awready;
    assign wready                 = s_r.wready;
    assign bvalid                 = s_r.bvalid;
    assign bresp                  = s_r.bresp;
    assign arready                = s_r.arready;
    assign rvalid                 = s_r.rvalid;
    assign rresp                  = s_r.rresp;
    assign rdata                  = s_r.rdata;
    assign gate_drive_high_enable = s_r.gdh;
    assign gate_discharge_enable  = s_r.gde;
    assign overflow_readback      = s_r.ovf_rb;
    assign irq                    = s_r.irq;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_DRIVE_EXCL: assert property (
        !(gate_drive_high_enable && gate_discharge_enable))
        else $error("drive and discharge enables both high");

    AST_CMP_DROPS: assert property (
        short_circuit_compare_out |=> !gate_drive_high_enable && s_r.fault_set)
        else $error("comparator fault did not drop drive enable");

    AST_OVF_HOLDS: assert property (
        s_r.ovf_flag |-> s_r.fault_set && !gate_drive_high_enable)
        else $error("overflow flag did not hold drive enable low");

    AST_HOLD_GATED: assert property (
        (!s_r.fault_set && !turnoff_rel) |=> $stable(hold_cnt))
        else $error("hold-off timer moved while not faulted");

    AST_EDGE_TRIP: assert property (
        (!s_r.ctrl.ride_mode && s_r.fault_set && s_r.osc_tick)
        |=> s_r.turnoff ##0 gate_discharge_enable)
        else $error("edge mode did not trip after one tick");

    AST_TRIP_DISCH: assert property (
        hold_hit |=> s_r.turnoff && gate_discharge_enable)
        else $error("hold-off overflow did not set turn-off");

    AST_ROSE_DISCH: assert property (
        $rose(s_r.turnoff) |-> gate_discharge_enable && !gate_drive_high_enable)
        else $error("turn-off latch not on discharge pin");

    AST_ACC_KEEP: assert property (
        (!s_r.fault_set && !acc_clr) |=> $stable(acc_cnt))
        else $error("accumulator changed between faults");

    AST_ACC_STEP: assert property (
        (acc_run && s_r.osc_tick && !acc_clr &&
         acc_cnt < s_r.ctrl.acc_period)
        |=> acc_cnt == $past(acc_cnt) + `SRRT_TIMER_W'(1))
        else $error("gated tick did not advance accumulator");

    AST_RB_FOLLOW: assert property (
        s_r.ovf_flag |=> overflow_readback)
        else $error("readback did not follow overflow flag");

    AST_ACC_CLEAR: assert property (
        (acc_clr && !acc_hit) |=> acc_cnt == '0 && !s_r.ovf_flag)
        else $error("firmware clear did not reset accumulator");

    AST_TRIP_STICKY: assert property (
        (s_r.turnoff && !turnoff_rel) |=> s_r.turnoff)
        else $error("turn-off latch released without firmware");

    AST_OVERCUR: assert property (
        (adc_valid && adc_result > `SRRT_LIMIT_COUNTS)
        |=> s_r.int_stat[`SRRT_EV_OVERCUR])
        else $error("over-current event not recorded");

    AST_HOLD_CAP: assert property (
        s_r.ctrl.ride_mode |-> hold_cnt <= s_r.ctrl.holdoff_ticks)
        else $error("hold-off count passed its period");

    COV_RIDE_TRIP: cover property (
        s_r.ctrl.ride_mode && $rose(s_r.turnoff));
    COV_EDGE_TRIP: cover property (
        !s_r.ctrl.ride_mode && $rose(s_r.turnoff));
    COV_ACC_OVF: cover property ($rose(s_r.ovf_flag));
    COV_IRQ: cover property ($rose(irq));

endmodule : srrt_top

// ===== tb/srrt_gate_model.sv
/* External gate driver and discharge transistor seen from the pins.
   Assumes both enables are sampled on aclk, active high. */
`timescale 1ns/1ps
module srrt_gate_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       drive_high,
    input  wire logic       discharge,
    output logic [1:0]      gate_level,
    output logic            clash_seen
);
    // Gate level: 2 full drive, 1 reduced drive, 0 discharged
    always_comb begin
        if (discharge) gate_level = 2'h0;
        else if (drive_high) gate_level = 2'h2;
        else gate_level = 2'h1;
    end
    // Sticky, so a one-cycle overlap is still seen at the end
    always_ff @(posedge aclk) begin
        if (!aresetn) clash_seen <= 1'b0;
        else if (drive_high && discharge) clash_seen <= 1'b1;
    end
endmodule : srrt_gate_model

// ===== tb/tb.sv
/* Self-checking bench for srrt_top over AXI4-Lite and the gate pins.
   Assumes srrt_params.svh on the include path and the gate model. */
`timescale 1ns/1ps
`include "srrt_params.svh"
module tb;
    logic        aclk = 1'b0, aresetn = 1'b0, cmp = 1'b0, adc_valid = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [9:0]  adc_result = 10'h000;
    logic [1:0]  bresp, rresp, gate_level;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        drv, dis, ovf, irq, clash;
    int          error_cnt = 0, total_checks = 0;
    always #50 aclk = ~aclk;
    srrt_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .short_circuit_compare_out(cmp),
        .adc_result(adc_result), .adc_valid(adc_valid),
        .gate_drive_high_enable(drv), .gate_discharge_enable(dis),
        .overflow_readback(ovf), .irq(irq));
    srrt_gate_model u_gate (.aclk(aclk), .aresetn(aresetn),
        .drive_high(drv), .discharge(dis), .gate_level(gate_level),
        .clash_seen(clash));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task tally_and_finish;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Bounded wait: a lost handshake ends the run with a mismatch
    task wait_hi(input int sel);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!((sel == 0 && awready === 1'b1) ||
                     (sel == 1 && bvalid === 1'b1) ||
                     (sel == 2 && arready === 1'b1) ||
                     (sel == 3 && rvalid === 1'b1) ||
                     (sel == 4 && dis === 1'b1)) && n < 40);
        if (n >= 40) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask : wait_hi
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        wait_hi(0);
        chk("wready", 32'h1, {31'h0, wready});
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wait_hi(1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
            input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        wait_hi(2);
        arvalid <= 1'b0;
        wait_hi(3);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        chk("rdata", e & m, rdata & m);
    endtask : rd
    // Comparator held high for n cycles, then idle settle
    task burst(input int n);
        @(posedge aclk) cmp <= 1'b1;
        repeat (n) @(posedge aclk);
        cmp <= 1'b0;
        repeat (3) @(posedge aclk);
        #1;
    endtask : burst
    task adc(input logic [9:0] v);
        @(posedge aclk) adc_result <= v;
        adc_valid <= 1'b1;
        @(posedge aclk) adc_valid <= 1'b0;
        repeat (3) @(posedge aclk);
        #1;
    endtask : adc
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk) #1;
        chk("dis_rst", 32'h0, {31'h0, dis});
        rd(`SRRT_ADDR_CTRL, `SRRT_CTRL_RST, '1, `SRRT_RESP_OKAY);
        rd(`SRRT_ADDR_LIMIT, 32'h1A6, '1, `SRRT_RESP_OKAY);
        rd(8'h40, 32'h0, '1, `SRRT_RESP_SLVERR);
        wr(8'h40, 32'hFFFF_FFFF, `SRRT_RESP_SLVERR);
        // Edge mode: one tick to trip, then turn-off holds
        wr(`SRRT_ADDR_CTRL, 32'h00FF_0101, `SRRT_RESP_OKAY);
        chk("gate_on", 32'h2, {30'h0, gate_level});
        @(posedge aclk) cmp <= 1'b1;
        repeat (2) @(posedge aclk);
        #1 chk("drv_fault", 32'h0, {31'h0, drv});
        wait_hi(4);
        #1 chk("dis_trip", 32'h1, {31'h0, dis});
        chk("gate_off", 32'h0, {30'h0, gate_level});
        cmp <= 1'b0;
        wr(`SRRT_ADDR_CMD, 32'h2, `SRRT_RESP_OKAY);
        chk("dis_hold", 32'h1, {31'h0, dis});
        chk("drv_hold", 32'h0, {31'h0, drv});
        wr(`SRRT_ADDR_CMD, 32'h1, `SRRT_RESP_OKAY);
        chk("dis_rel", 32'h0, {31'h0, dis});
        chk("drv_back", 32'h1, {31'h0, drv});
        // Ride mode: period 4, bursts of 2 and 3 ticks add up
        wr(`SRRT_ADDR_CTRL, 32'h0004_FF07, `SRRT_RESP_OKAY);
        burst(6);
        rd(`SRRT_ADDR_STATUS, 32'h0200, 32'hFF00, `SRRT_RESP_OKAY);
        chk("ovf_lo", 32'h0, {31'h0, ovf});
        burst(9);
        chk("ovf_hi", 32'h1, {31'h0, ovf});
        chk("drv_ovf", 32'h0, {31'h0, drv});
        wr(`SRRT_ADDR_CMD, 32'h2, `SRRT_RESP_OKAY);
        chk("drv_refuse", 32'h0, {31'h0, drv});
        wr(`SRRT_ADDR_CMD, 32'h4, `SRRT_RESP_OKAY);
        repeat (3) @(posedge aclk);
        #1 chk("ovf_clr", 32'h0, {31'h0, ovf});
        chk("drv_ride", 32'h1, {31'h0, drv});
        rd(`SRRT_ADDR_STATUS, 32'h0, 32'hFF00, `SRRT_RESP_OKAY);
        // Interrupts: over-current event at the limit boundary
        wr(`SRRT_ADDR_INT_STAT, 32'hF, `SRRT_RESP_OKAY);
        wr(`SRRT_ADDR_INT_MASK, 32'h8, `SRRT_RESP_OKAY);
        adc(10'h1A6);
        chk("irq_at", 32'h0, {31'h0, irq});
        adc(10'h1A7);
        chk("irq_over", 32'h1, {31'h0, irq});
        wr(`SRRT_ADDR_INT_MASK, 32'h0, `SRRT_RESP_OKAY);
        chk("irq_mask", 32'h0, {31'h0, irq});
        wr(`SRRT_ADDR_INT_STAT, 32'h8, `SRRT_RESP_OKAY);
        wr(`SRRT_ADDR_INT_MASK, 32'h8, `SRRT_RESP_OKAY);
        chk("irq_clr", 32'h0, {31'h0, irq});
        chk("clash", 32'h0, {31'h0, clash});
        tally_and_finish();
    end
endmodule : tb
